//--- bench/serial_comm_block_chk.sv
// port-level assertions for the serial communication block
`timescale 1ns/1ps
module serial_comm_block_chk
  import serial_comm_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire power_mode_e powerMode,
  input wire spi_cfg_s spiCfg,
  input wire logic spiSsN,
  input wire logic spiMiso,
  input wire logic spiMisoOe,
  input wire logic wakeupMask,
  input wire logic wakeupClear,
  input wire logic wakeupCause,
  input wire logic wakeupIrq,
  input wire logic cpuReq,
  input wire logic cpuAck,
  input wire logic cpuErr,
  input wire logic cpuWait,
  input wire uart_cfg_s uartCfg,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic uartTx
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_invalid_silent: assert property (spiCfg == 3'h2 |-> !spiMisoOe)
    else $error("miso driven in invalid setting");
  chk_deep_silent: assert property ((spiCfg == 3'h0
    && powerMode == PWR_DEEPSLEEP) |-> !spiMisoOe)
    else $error("miso driven in deep sleep internal");
  chk_wake_set: assert property (($fell(spiSsN)
    && spiCfg == 3'h4) |-> ##[1:6] wakeupCause)
    else $error("wake cause not set");
  chk_wake_hold: assert property (wakeupCause && !wakeupClear
    |=> wakeupCause)
    else $error("wake cause lost");
  chk_irq_mask: assert property (wakeupCause && wakeupMask
    |=> wakeupIrq)
    else $error("wake irq missing");
  chk_deep_ones: assert property ((spiMisoOe && spiCfg == 3'h4
    && powerMode == PWR_DEEPSLEEP) |-> spiMiso)
    else $error("miso not all ones in deep sleep");
  chk_cpu_answer: assert property (cpuReq |=> cpuAck ^ cpuWait)
    else $error("cpu request not answered once");
  chk_err_cause: assert property (cpuErr
    |-> cpuAck && $past(spiCfg) == 3'h6)
    else $error("bus error outside external no-wait");
  chk_tx_start: assert property (txValid && txReady
    |=> !uartTx && !txReady)
    else $error("start bit missing");
  chk_tx_idle: assert property ((txReady
    && uartCfg.mode != UART_SMARTCARD) |-> uartTx)
    else $error("tx line not idle high");
endmodule
bind serial_comm_block serial_comm_block_chk chk_i (.clk(clk),
  .arst_n(arst_n), .powerMode(powerMode), .spiCfg(spiCfg),
  .spiSsN(spiSsN), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
  .wakeupMask(wakeupMask), .wakeupClear(wakeupClear),
  .wakeupCause(wakeupCause), .wakeupIrq(wakeupIrq), .cpuReq(cpuReq),
  .cpuAck(cpuAck), .cpuErr(cpuErr), .cpuWait(cpuWait),
  .uartCfg(uartCfg), .txValid(txValid), .txReady(txReady),
  .uartTx(uartTx));

//--- bench/spi_master_model.sv
// spi master partner: mode 0 frames, msb first
`timescale 1ns/1ps
module spi_master_model
(
  output logic sclk,
  output logic ssN,
  output logic mosi,
  input wire logic miso
);
  initial
  begin
    sclk = 1'b0;
    ssN = 1'b1;
    mosi = 1'b0;
  end
  // pin edges run free of the block clock on purpose
  task automatic frame(input int n, input logic [7:0] t[4],
                       output logic [7:0] r[4]);
    ssN = 1'b0;
    #500;
    for (int i = 0; i < n; i++)
      for (int b = 7; b >= 0; b--)
      begin
        mosi = t[i][b];
        #62.5 sclk = 1'b1;
        r[i][b] = miso;
        #62.5 sclk = 1'b0;
      end
    #200 ssN = 1'b1;
    // released line shows the opposite of its last bit
    mosi = ~mosi;
    #500;
  endtask
endmodule

//--- bench/tb_serial_comm_block.sv
// self-checking bench for the serial communication block
`timescale 1ns/1ps
module tb_serial_comm_block
  import serial_comm_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  power_mode_e powerMode = PWR_ACTIVE;
  spi_cfg_s spiCfg = '0;
  logic wakeupMask = 1'b0, wakeupClear = 1'b0, noise = 1'b0;
  logic cpuReq = 1'b0, cpuWe = 1'b0, txValid = 1'b0;
  logic [4:0] cpuAddr = '0;
  logic [7:0] cpuWdata = '0, halfBitCycles = 8'h11;
  logic [8:0] txData = '0;
  uart_cfg_s uartCfg = '{4'h8, 4'h2, 1'b0, 1'b0, UART_STD};
  logic spiSclk, spiSsN, spiMosi, spiMiso, spiMisoOe, wakeupCause;
  logic wakeupIrq, cpuAck, cpuErr, cpuWait, txReady, uartTx, rxValid;
  logic collision;
  logic [7:0] cpuRdata;
  logic [15:0] lowRunCycles;
  uart_rx_s rxWord;
  logic [7:0] tx[4], rx[4];
  int numErrors = 0, totalChecks = 0;
  // undriven miso toggles so a stale value never passes
  wire misoLine = spiMisoOe ? spiMiso : noise;
  always #5 clk = ~clk;
  always @(posedge clk) noise <= ~noise;
  serial_comm_block dut (.clk, .arst_n, .powerMode, .spiCfg, .spiSclk,
    .spiSsN, .spiMosi, .spiMiso, .spiMisoOe, .wakeupMask, .wakeupClear,
    .wakeupCause, .wakeupIrq, .cpuReq, .cpuWe, .cpuAddr, .cpuWdata,
    .cpuAck, .cpuErr, .cpuWait, .cpuRdata, .uartCfg, .halfBitCycles,
    .txValid, .txData, .txReady, .uartTx, .uartRx(uartTx), .rxValid,
    .rxWord, .collision, .lowRunCycles);
  spi_master_model spiMaster (.sclk(spiSclk), .ssN(spiSsN), .mosi(spiMosi),
    .miso(misoLine));
  task chk(input string n, input logic [8:0] e, input logic [8:0] s);
    totalChecks++;
    if (s !== e)
    begin
      numErrors++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task setup(input spi_cfg_s c, input power_mode_e p);
    @(posedge clk);
    spiCfg <= c;
    powerMode <= p;
  endtask
  task spi(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
    tx = '{a, d0, d1, 8'h00};
    spiMaster.frame(3, tx, rx);
  endtask
  task cpu_rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    cpuReq <= 1'b1;
    cpuAddr <= a;
    @(posedge clk);
    cpuReq <= 1'b0;
    @(negedge clk);
    chk("cpuRdata", {1'b1, e}, {cpuAck, cpuRdata});
  endtask
  task t_internal;
    setup(3'h0, PWR_ACTIVE);
    spi(8'h85, 8'hA5, 8'h3C);
    spi(8'h9F, 8'h11, 8'h22);
    spi(8'h05, 8'h00, 8'h00);
    chk("spiRead", 9'h0FF, {1'b0, rx[0]});
    chk("spiRead", 9'h0A5, {1'b0, rx[1]});
    chk("spiRead", 9'h03C, {1'b0, rx[2]});
    cpu_rd(5'h05, 8'hA5);
    cpu_rd(5'h00, 8'h22);
    $display("test internal done");
  endtask
  task t_refused;
    setup(3'h2, PWR_ACTIVE);
    spi(8'h85, 8'h11, 8'h11);
    setup(3'h0, PWR_DEEPSLEEP);
    spi(8'h85, 8'h11, 8'h11);
    setup(3'h0, PWR_ACTIVE);
    cpu_rd(5'h05, 8'hA5);
    $display("test refused done");
  endtask
  task t_deepsleep;
    @(posedge clk);
    wakeupMask <= 1'b1;
    setup(3'h4, PWR_DEEPSLEEP);
    spi(8'h05, 8'h00, 8'h00);
    chk("nackByte", 9'h1FF, {rx[1], rx[2][0]});
    chk("wake", 9'h003, {7'h00, wakeupCause, wakeupIrq});
    @(posedge clk);
    wakeupClear <= 1'b1;
    wakeupMask <= 1'b0;
    powerMode <= PWR_ACTIVE;
    @(posedge clk);
    wakeupClear <= 1'b0;
    @(negedge clk);
    chk("wakeClear", 9'h000, {8'h00, wakeupCause});
    spi(8'h05, 8'h00, 8'h00);
    chk("nextRead", 9'h0A5, {1'b0, rx[1]});
    $display("test deep sleep done");
  endtask
  task t_conflict;
    int nErr, nWait;
    for (int w = 0; w < 2; w++)
    begin
      nErr = 0;
      nWait = 0;
      setup({2'b11, w[0]}, PWR_DEEPSLEEP);
      fork
        spi(8'h88, 8'h5A, 8'h00);
      join_none
      @(posedge clk);
      cpuReq <= 1'b1;
      cpuAddr <= 5'h08;
      repeat (450)
      begin
        @(negedge clk);
        nErr += cpuErr;
        nWait += cpuWait;
      end
      @(posedge clk);
      cpuReq <= 1'b0;
      wait fork;
      chk("conflict", {7'h00, !w[0], w[0]},
          {7'h00, nErr > 0, nWait > 0});
      cpu_rd(5'h08, 8'h5A);
    end
    $display("test conflict done");
  endtask
  task t_uart;
    uart_cfg_s c[4];
    logic [8:0] d[4];
    int k;
    c = '{'{4'h4, 4'h2, 1'b1, 1'b0, UART_STD},
          '{4'h9, 4'h8, 1'b1, 1'b1, UART_SMARTCARD},
          '{4'h8, 4'h3, 1'b0, 1'b0, UART_IRDA},
          '{4'h5, 4'h4, 1'b1, 1'b1, UART_IRDA}};
    d = '{9'h00B, 9'h1A5, 9'h0C3, 9'h015};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      uartCfg <= c[i];
      txData <= d[i];
      txValid <= 1'b1;
      @(posedge clk);
      txValid <= 1'b0;
      k = 0;
      while (rxValid !== 1'b1 && k < 3000)
      begin
        @(negedge clk);
        k++;
      end
      chk("rxValid", 9'h001, {8'h00, rxValid});
      chk("rxData", d[i] & (9'h1FF >> (4'h9 - c[i].dataBits)),
          rxWord.data);
      chk("rxFlags", 9'h000, {6'h00, rxWord.parityErr, rxWord.frameErr,
          rxWord.breakSeen});
      repeat (300) @(posedge clk);
      chk("txReady", 9'h001, {8'h00, txReady});
    end
    $display("test uart done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #600000;
    numErrors++;
    final_report;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk("idle", 9'h006, {6'h00, uartTx, txReady, spiMisoOe});
    t_internal;
    t_refused;
    t_deepsleep;
    t_conflict;
    t_uart;
    final_report;
  end
endmodule

//--- common/serial_comm_pkg.sv
// constants, types and framing limits for the serial communication block
// What this block does
// - selection internal with operation external is invalid: block stays silent
// - both selectors zero: everything internal, works in Active and Sleep only
// - mixed setting: external selection detection sets a sticky wakeup cause
// - mixed setting: both halves run in Active, only selection in Deep-Sleep
// - mixed setting in Sleep: internal logic completes the selected transfer
// - mixed setting in Deep-Sleep: transfer answered with all ones
// - both selectors one: external operation in all modes, memory reached externally
// - memory conflicts insert wait states when bit is 1 or operation is internal, bus errors when 0 with external operation
// - character is start bit, data bits, optional parity, stop bits
// - data field defaults to eight bits, configurable four to nine
// - stop interval set in half bits, from one to four bits
// - parity even or odd, generated and checked, standard and smart-card
// - infrared mode forces parity off
// - received parity bit flags single bit errors
// - bit rate at most 3 Mbps, bit period programmable in clocks
// - the UART runs only on the internal clock
// - LIN collision, break detection and bit period measurement
// - smart-card mode can answer a bad character with a negative acknowledge
// - selection and operation selectors: 0 internal, 1 external
// - memory-slave mode uses the SRAM as addressable memory
// - start bit 0, stop bits 1, idle line 1
// - receiver resynchronises on each falling edge into a start bit
package serial_comm_pkg;
  typedef enum logic [1:0] {PWR_ACTIVE, PWR_SLEEP, PWR_DEEPSLEEP} power_mode_e;
  typedef enum logic [1:0] {UART_STD, UART_SMARTCARD, UART_IRDA} uart_mode_e;
  typedef struct packed {
    logic selectionClockSourceSel;
    logic operationClockSourceSel;
    logic waitOnConflict;
  } spi_cfg_s;
  typedef struct packed {
    logic [3:0] dataBits;
    logic [3:0] stopHalfBits;
    logic parityEn;
    logic parityOdd;
    uart_mode_e mode;
  } uart_cfg_s;
  typedef struct packed {
    logic [8:0] data;
    logic parityErr;
    logic frameErr;
    logic breakSeen;
  } uart_rx_s;
  localparam logic [7:0] SPI_IDLE_BYTE = 8'hFF;
  localparam int SPI_WRITE_BIT = 7;
  localparam int SPI_ADDR_BITS_MAX = 7;
  localparam logic [2:0] SPI_LAST_BIT = 3'h7;
  localparam logic [3:0] DATA_BITS_MIN = 4'h4;
  localparam logic [3:0] DATA_BITS_MAX = 4'h9;
  localparam logic [3:0] DATA_BITS_DEFAULT = 4'h8;
  localparam logic [3:0] STOP_HALF_MIN = 4'h2;
  localparam logic [3:0] STOP_HALF_MAX = 4'h8;
  localparam logic [3:0] HALVES_PER_BIT = 4'h2;
  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int UART_MAX_BPS = 3_000_000;
  // least half bit period, rounded up to whole cycles
  localparam int MIN_HALF_INT = (CLK_FREQ_HZ + 2 * UART_MAX_BPS - 1)
                                / (2 * UART_MAX_BPS);
  localparam logic [7:0] MIN_HALF_CYCLES = MIN_HALF_INT[7:0];
  localparam int SYNC_RX = 3;
  localparam int SYNC_SSN = 2;
  localparam int SYNC_SCLK = 1;
  localparam int SYNC_MOSI = 0;
endpackage

//--- rtl/serial_comm_block.sv
// spi memory slave with clock-source settings and a uart transceiver
`timescale 1ns/1ps
module serial_comm_block
  import serial_comm_pkg::*;
#(
  parameter int ADDR_BITS = 5
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire power_mode_e powerMode,
  input wire spi_cfg_s spiCfg,
  input wire logic spiSclk,
  input wire logic spiSsN,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoOe,
  input wire logic wakeupMask,
  input wire logic wakeupClear,
  output logic wakeupCause,
  output logic wakeupIrq,
  input wire logic cpuReq,
  input wire logic cpuWe,
  input wire logic [ADDR_BITS-1:0] cpuAddr,
  input wire logic [7:0] cpuWdata,
  output logic cpuAck,
  output logic cpuErr,
  output logic cpuWait,
  output logic [7:0] cpuRdata,
  input wire uart_cfg_s uartCfg,
  input wire logic [7:0] halfBitCycles,
  input wire logic txValid,
  input wire logic [8:0] txData,
  output logic txReady,
  output logic uartTx,
  input wire logic uartRx,
  output logic rxValid,
  output uart_rx_s rxWord,
  output logic collision,
  output logic [15:0] lowRunCycles
);
  localparam int DEPTH = 1 << ADDR_BITS;
  initial
  begin
    if (ADDR_BITS < 1 || ADDR_BITS > SPI_ADDR_BITS_MAX)
      $error("ADDR_BITS out of range");
  end

  logic [1:0] rstSync;
  logic rstN;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rstSync <= 2'b00;
    else
      rstSync <= {rstSync[0], 1'b1};
  end
  assign rstN = rstSync[1];

  // pins and the spi clock come from outside: two flops first
  logic [3:0] sync1, sync2;
  logic sclkPrev_reg, ssPrev_reg;
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      // reset to the idle levels of the pins so no false edge follows
      sync1 <= 4'hC;
      sync2 <= 4'hC;
      sclkPrev_reg <= 1'b0;
      ssPrev_reg <= 1'b1;
    end
    else
    begin
      sync1 <= {uartRx, spiSsN, spiSclk, spiMosi};
      sync2 <= sync1;
      sclkPrev_reg <= sync2[SYNC_SCLK];
      ssPrev_reg <= sync2[SYNC_SSN];
    end
  end
  logic sclkRise, sclkFall, selEdge, rxSync;
  assign sclkRise = sync2[SYNC_SCLK] && !sclkPrev_reg;
  assign sclkFall = !sync2[SYNC_SCLK] && sclkPrev_reg;
  assign selEdge = ssPrev_reg && !sync2[SYNC_SSN];
  assign rxSync = sync2[SYNC_RX];

  logic invalidCfg, extOp, mixedCfg, intOnly, deepSleep, respond;
  assign invalidCfg = !spiCfg.selectionClockSourceSel
                      && spiCfg.operationClockSourceSel;
  assign extOp = spiCfg.selectionClockSourceSel
                 && spiCfg.operationClockSourceSel;
  assign mixedCfg = spiCfg.selectionClockSourceSel
                    && !spiCfg.operationClockSourceSel;
  assign intOnly = !spiCfg.selectionClockSourceSel
                   && !spiCfg.operationClockSourceSel;
  assign deepSleep = powerMode == PWR_DEEPSLEEP;
  // internal-only operation stops in deep sleep
  assign respond = !invalidCfg && !(intOnly && deepSleep);

  logic [7:0] mem_reg [DEPTH];
  logic [7:0] mem_next [DEPTH];
  logic selected_reg, selected_next;
  logic [2:0] bitCnt_reg, bitCnt_next;
  logic [7:0] rxShift_reg, rxShift_next, txShift_reg, txShift_next;
  logic [ADDR_BITS-1:0] addr_reg, addr_next;
  logic writeMode_reg, writeMode_next, first_reg, first_next;
  logic nack_reg, nack_next, miso_reg, miso_next, oe_reg, oe_next;
  logic wake_reg, wake_next, irq_reg, irq_next;
  logic ack_reg, ack_next, err_reg, err_next, wait_reg, wait_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] byteVal;
  logic byteDone, spiAcc, spiWr, conflict;
  logic [ADDR_BITS-1:0] accAddr;

  assign byteVal = {rxShift_reg[6:0], sync2[SYNC_MOSI]};
  assign byteDone = selected_reg && sclkRise && bitCnt_reg == SPI_LAST_BIT;
  // sram as an addressable array: first byte is write flag and address
  assign spiAcc = byteDone && !nack_reg
                  && !(first_reg && byteVal[SPI_WRITE_BIT]);
  assign spiWr = spiAcc && !first_reg && writeMode_reg;
  assign accAddr = (first_reg || writeMode_reg) ?
                   (first_reg ? byteVal[ADDR_BITS-1:0] : addr_reg) :
                   addr_reg + {{(ADDR_BITS-1){1'b0}}, 1'b1};
  assign conflict = cpuReq && spiAcc;

  always_comb
  begin
    selected_next = selected_reg;
    bitCnt_next = bitCnt_reg;
    rxShift_next = rxShift_reg;
    txShift_next = txShift_reg;
    addr_next = addr_reg;
    writeMode_next = writeMode_reg;
    first_next = first_reg;
    nack_next = nack_reg;
    miso_next = miso_reg;
    if (selEdge)
    begin
      selected_next = respond;
      // deep sleep in the mixed setting: only selection is alive
      nack_next = mixedCfg && deepSleep;
      txShift_next = SPI_IDLE_BYTE;
      miso_next = 1'b1;
      bitCnt_next = 3'h0;
      first_next = 1'b1;
    end
    else if (sync2[SYNC_SSN])
      selected_next = 1'b0;
    else if (selected_reg)
    begin
      // in sleep the mixed setting runs the transfer here
      if (sclkRise)
      begin
        rxShift_next = byteVal;
        bitCnt_next = bitCnt_reg + 3'h1;
      end
      if (byteDone)
      begin
        first_next = 1'b0;
        if (first_reg)
        begin
          addr_next = byteVal[ADDR_BITS-1:0];
          writeMode_next = byteVal[SPI_WRITE_BIT];
        end
        else
          addr_next = writeMode_reg ?
                      addr_reg + {{(ADDR_BITS-1){1'b0}}, 1'b1} : accAddr;
        txShift_next = nack_reg ? SPI_IDLE_BYTE : mem_reg[accAddr];
      end
      if (sclkFall)
      begin
        miso_next = txShift_reg[7];
        txShift_next = {txShift_reg[6:0], 1'b1};
      end
    end
  end

  always_comb
  begin
    mem_next = mem_reg;
    ack_next = 1'b0;
    err_next = 1'b0;
    wait_next = 1'b0;
    rdata_next = rdata_reg;
    oe_next = selected_next;
    // set wins over a clear in the same cycle
    wake_next = (wake_reg && !wakeupClear) || (selEdge && mixedCfg);
    // mask is software's to set per power mode
    irq_next = wake_next && wakeupMask;
    if (spiWr)
      mem_next[addr_reg] = byteVal;
    if (conflict)
    begin
      // internal spi accesses always stall the cpu; only external ones err
      if (spiCfg.waitOnConflict || !extOp)
        wait_next = 1'b1;
      else
      begin
        ack_next = 1'b1;
        err_next = 1'b1;
      end
    end
    else if (cpuReq)
    begin
      ack_next = 1'b1;
      if (cpuWe)
        mem_next[cpuAddr] = cpuWdata;
      else
        rdata_next = mem_reg[cpuAddr];
    end
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      selected_reg <= 1'b0;
      bitCnt_reg <= 3'h0;
      rxShift_reg <= 8'h00;
      txShift_reg <= SPI_IDLE_BYTE;
      addr_reg <= '0;
      writeMode_reg <= 1'b0;
      first_reg <= 1'b1;
      nack_reg <= 1'b0;
      miso_reg <= 1'b1;
      oe_reg <= 1'b0;
      wake_reg <= 1'b0;
      irq_reg <= 1'b0;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      wait_reg <= 1'b0;
      rdata_reg <= 8'h00;
      for (int i = 0; i < DEPTH; i++)
        mem_reg[i] <= 8'h00;
    end
    else
    begin
      selected_reg <= selected_next;
      bitCnt_reg <= bitCnt_next;
      rxShift_reg <= rxShift_next;
      txShift_reg <= txShift_next;
      addr_reg <= addr_next;
      writeMode_reg <= writeMode_next;
      first_reg <= first_next;
      nack_reg <= nack_next;
      miso_reg <= miso_next;
      oe_reg <= oe_next;
      wake_reg <= wake_next;
      irq_reg <= irq_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      mem_reg <= mem_next;
    end
  end

  // uart transmitter, internal clock only
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP,
                            TX_NACK} tx_state_e;
  tx_state_e tx_reg, tx_next;
  logic [7:0] timer_reg, timer_next, halfEff;
  logic [3:0] halves_reg, halves_next, idx_reg, idx_next, stopHalves;
  logic [8:0] txBuf_reg, txBuf_next;
  logic pin_reg, pin_next, ready_reg, ready_next, coll_reg, coll_next;
  logic parityOn, halfDone, rxDone, nackReq;
  uart_rx_s rxW;

  // bit period never shorter than the fastest rate allows
  assign halfEff = halfBitCycles < MIN_HALF_CYCLES ? MIN_HALF_CYCLES
                   : halfBitCycles;
  assign stopHalves = uartCfg.stopHalfBits < STOP_HALF_MIN ? STOP_HALF_MIN
                      : uartCfg.stopHalfBits > STOP_HALF_MAX ? STOP_HALF_MAX
                      : uartCfg.stopHalfBits;
  assign parityOn = uartCfg.parityEn && uartCfg.mode != UART_IRDA;
  assign halfDone = timer_reg == 8'h00;
  assign nackReq = rxDone && rxW.parityErr
                   && uartCfg.mode == UART_SMARTCARD;

  always_comb
  begin
    tx_next = tx_reg;
    timer_next = halfDone ? halfEff - 8'h01 : timer_reg - 8'h01;
    halves_next = halves_reg;
    idx_next = idx_reg;
    txBuf_next = txBuf_reg;
    coll_next = 1'b0;
    if (halfDone && halves_reg != 4'h0)
      halves_next = halves_reg - 4'h1;
    // mid-bit check of a driven bit against the line
    if (halfDone && halves_reg == HALVES_PER_BIT && tx_reg != TX_IDLE
        && tx_reg != TX_NACK && uartCfg.mode == UART_STD)
      coll_next = rxSync != pin_reg;
    unique case (tx_reg)
      TX_IDLE:
        if (nackReq)
        begin
          tx_next = TX_NACK;
          halves_next = HALVES_PER_BIT;
          timer_next = halfEff - 8'h01;
        end
        else if (txValid && ready_reg)
        begin
          tx_next = TX_START;
          txBuf_next = txData;
          idx_next = 4'h0;
          halves_next = HALVES_PER_BIT;
          timer_next = halfEff - 8'h01;
        end
      TX_START, TX_DATA, TX_PARITY, TX_NACK:
        if (halfDone && halves_reg == 4'h1)
        begin
          halves_next = HALVES_PER_BIT;
          if (tx_reg == TX_NACK)
            tx_next = TX_IDLE;
          else if (tx_reg == TX_PARITY)
          begin
            tx_next = TX_STOP;
            halves_next = stopHalves;
          end
          else if (tx_reg == TX_DATA && idx_reg == uartCfg.dataBits - 4'h1)
          begin
            tx_next = parityOn ? TX_PARITY : TX_STOP;
            halves_next = parityOn ? HALVES_PER_BIT : stopHalves;
          end
          else
          begin
            if (tx_reg == TX_DATA)
              idx_next = idx_reg + 4'h1;
            tx_next = TX_DATA;
          end
        end
      TX_STOP:
        if (halfDone && halves_reg == 4'h1)
          tx_next = TX_IDLE;
      default:
        tx_next = TX_IDLE;
    endcase
    ready_next = tx_next == TX_IDLE && !nackReq;
    unique case (tx_next)
      TX_START, TX_NACK:
        pin_next = 1'b0;
      TX_DATA:
        pin_next = txBuf_next[idx_next];
      // parity over the data field only
      TX_PARITY:
        pin_next = ^(txBuf_reg & ~(9'h1FF << uartCfg.dataBits))
                   ^ uartCfg.parityOdd;
      default:
        pin_next = 1'b1;
    endcase
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      tx_reg <= TX_IDLE;
      timer_reg <= 8'h00;
      halves_reg <= 4'h0;
      idx_reg <= 4'h0;
      txBuf_reg <= 9'h000;
      pin_reg <= 1'b1;
      ready_reg <= 1'b0;
      coll_reg <= 1'b0;
    end
    else
    begin
      tx_reg <= tx_next;
      timer_reg <= timer_next;
      halves_reg <= halves_next;
      idx_reg <= idx_next;
      txBuf_reg <= txBuf_next;
      pin_reg <= pin_next;
      ready_reg <= ready_next;
      coll_reg <= coll_next;
    end
  end

  uart_rx rxUnit (
    .clk(clk),
    .rstN(rstN),
    .rxIn(rxSync),
    .cfg(uartCfg),
    .halfCycles(halfEff),
    .rxValid(rxDone),
    .rxWord(rxW),
    .lowRunCycles(lowRunCycles)
  );

  assign spiMiso = miso_reg;
  assign spiMisoOe = oe_reg;
  assign wakeupCause = wake_reg;
  assign wakeupIrq = irq_reg;
  assign cpuAck = ack_reg;
  assign cpuErr = err_reg;
  assign cpuWait = wait_reg;
  assign cpuRdata = rdata_reg;
  assign txReady = ready_reg;
  assign uartTx = pin_reg;
  assign rxValid = rxDone;
  assign rxWord = rxW;
  assign collision = coll_reg;
endmodule

//--- rtl/uart_rx.sv
// uart receiver with parity check, break flag and low-run measurement
`timescale 1ns/1ps
module uart_rx
  import serial_comm_pkg::*;
(
  input wire logic clk,
  input wire logic rstN,
  input wire logic rxIn,
  input wire uart_cfg_s cfg,
  input wire logic [7:0] halfCycles,
  output logic rxValid,
  output uart_rx_s rxWord,
  output logic [15:0] lowRunCycles
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP}
    rx_state_e;
  rx_state_e state_reg, state_next;
  logic [8:0] timer_reg, timer_next;
  logic [3:0] idx_reg, idx_next;
  logic [8:0] data_reg, data_next;
  logic perr_reg, perr_next;
  logic valid_reg, valid_next;
  uart_rx_s word_reg, word_next;
  logic rxPrev_reg;
  logic [15:0] run_reg, run_next, meas_reg, meas_next;
  logic parityOn;
  logic [8:0] fullBit;
  assign parityOn = cfg.parityEn && cfg.mode != UART_IRDA;
  assign fullBit = {halfCycles, 1'b0};
  always_comb
  begin
    state_next = state_reg;
    timer_next = timer_reg;
    idx_next = idx_reg;
    data_next = data_reg;
    perr_next = perr_reg;
    valid_next = 1'b0;
    word_next = word_reg;
    if (timer_reg != 9'h000)
      timer_next = timer_reg - 9'h001;
    unique case (state_reg)
      RX_IDLE:
        if (rxPrev_reg && !rxIn)
        begin
          state_next = RX_START;
          timer_next = {1'b0, halfCycles};
          data_next = 9'h000;
          idx_next = 4'h0;
          perr_next = 1'b0;
        end
      RX_START:
        if (timer_reg == 9'h000)
        begin
          // glitch shorter than half a bit is dropped
          state_next = rxIn ? RX_IDLE : RX_DATA;
          timer_next = fullBit;
        end
      RX_DATA:
        if (timer_reg == 9'h000)
        begin
          data_next[idx_reg] = rxIn;
          idx_next = idx_reg + 4'h1;
          timer_next = fullBit;
          if (idx_reg == cfg.dataBits - 4'h1)
            state_next = parityOn ? RX_PARITY : RX_STOP;
        end
      RX_PARITY:
        if (timer_reg == 9'h000)
        begin
          // data bits above the field width stay zero
          perr_next = rxIn != (^data_reg ^ cfg.parityOdd);
          state_next = RX_STOP;
          timer_next = fullBit;
        end
      RX_STOP:
        if (timer_reg == 9'h000)
        begin
          valid_next = 1'b1;
          word_next.data = data_reg;
          word_next.parityErr = perr_reg;
          word_next.frameErr = !rxIn;
          word_next.breakSeen = !rxIn && data_reg == 9'h000;
          state_next = RX_IDLE;
        end
      default:
        state_next = RX_IDLE;
    endcase
  end
  always_comb
  begin
    run_next = rxIn ? 16'h0000 : run_reg + {15'h0000, run_reg != 16'hFFFF};
    meas_next = meas_reg;
    if (!rxPrev_reg && rxIn)
      meas_next = run_reg;
  end
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_reg <= RX_IDLE;
      timer_reg <= 9'h000;
      idx_reg <= 4'h0;
      data_reg <= 9'h000;
      perr_reg <= 1'b0;
      valid_reg <= 1'b0;
      word_reg <= '0;
      rxPrev_reg <= 1'b1;
      run_reg <= 16'h0000;
      meas_reg <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      idx_reg <= idx_next;
      data_reg <= data_next;
      perr_reg <= perr_next;
      valid_reg <= valid_next;
      word_reg <= word_next;
      rxPrev_reg <= rxIn;
      run_reg <= run_next;
      meas_reg <= meas_next;
    end
  end
  assign rxValid = valid_reg;
  assign rxWord = word_reg;
  assign lowRunCycles = meas_reg;
endmodule
